// ===== verilog/mcb_top.sv
// Purpose: AHB-Lite slave holding the host command image and the module status image for two axes
// Assumes: single word transfers, inputs synchronous to hclk
// Notes:   zero wait states; every output is a flip-flop
//
// Summary of operation
// - change on bit 18 enables drive A
// - change on bit 34 enables drive B
// - change on bit 0 clears pending error
// - change on bit 19 homes axis A
// - change on bit 35 homes axis B
// - axis A homed sets status bit 17
// - axis B homed sets status bit 33
// - bit 1 enables logic; run only without error
// - change on bit 2 runs program one, A
// - change on bit 3 runs program two, B
// - cam slave position from table by master
// - statements in order; dwell holds, then continues
//
// The AHB-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "mcb_params.svh"
module mcb_top import mcb_pkg::*; #(
  parameter int PW        = 16,
  parameter int AW        = 3,
  parameter int CAM_AW    = 3,
  parameter int CAM_SHIFT = 10,
  parameter int HOME_CYC  = `MCB_HOME_CYC
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // fault report from the drive side
  input  wire logic        fault,
  // drive and status outputs
  output logic             drive_en_a,
  output logic             drive_en_b,
  output logic             pos_valid_a,
  output logic             pos_valid_b,
  output logic             err_pending,
  output logic             irq
);

  localparam int PD = 1 << AW;
  localparam int CD = 1 << CAM_AW;

  // --------------------------------------------------------------------------
  // register storage
  // --------------------------------------------------------------------------
  logic [63:0]          cmd_q;
  logic [63:0]          cmd_prev_q;
  logic [`MCB_IRQ_W-1:0] irq_stat_q;
  logic [`MCB_IRQ_W-1:0] irq_mask_q;
  logic [PW-1:0]        cam_q [CD];
  logic [15:0]          prog_q [2][PD];
  logic                 logic_en_q;

  // bus phase capture
  logic                 wr_pend_q;
  logic [7:0]           wr_addr_q;
  logic                 take;
  logic [7:0]           a8;

  // axis wiring
  logic [63:0]          chg;
  logic [1:0]           home_go;
  logic [1:0]           run_go;
  logic [1:0]           run_req;
  logic [1:0]           drv_en;
  logic [AW-1:0]        pc [2];
  logic [PW-1:0]        pos [2];
  logic [1:0]           pvalid, busy, dwell, home_done, prog_done;
  logic                 refused;

  // address phase taken when selected, ready and a real transfer
  assign take = hsel && hready && htrans[1];
  assign a8   = haddr[7:0];

  // word decode used by both read and write paths
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
    is_reg = (a[7:2] == ofs[7:2]);
  endfunction : is_reg

  // --------------------------------------------------------------------------
  // bus data phase
  // --------------------------------------------------------------------------
  // always ready, always okay: no wait states in this block
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // write address held into the data phase, hwdata taken at its end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= take && hwrite;
      wr_addr_q <= a8;
    end
  end

  // command image; writes only change what the host means to change
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_q      <= 64'h0;
      cmd_prev_q <= 64'h0;
    end else begin
      cmd_prev_q <= cmd_q;
      if (wr_pend_q && is_reg(wr_addr_q, `MCB_OFS_CMD_LO)) begin
        cmd_q[31:0] <= hwdata;
      end
      if (wr_pend_q && is_reg(wr_addr_q, `MCB_OFS_CMD_HI)) begin
        cmd_q[63:32] <= hwdata;
      end
    end
  end

  // interrupt mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_q <= `MCB_IRQ_MASK_RST;
    end else if (wr_pend_q && is_reg(wr_addr_q, `MCB_OFS_IRQ_MASK)) begin
      irq_mask_q <= hwdata[`MCB_IRQ_W-1:0];
    end
  end

  // cam table and program storage, one word each
  genvar gi, gj;
  generate
    for (gi = 0; gi < CD; gi++) begin : g_cam
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cam_q[gi] <= '0;
        end else if (wr_pend_q && wr_addr_q == 8'(`MCB_OFS_CAM_BASE + 4 * gi)) begin
          cam_q[gi] <= hwdata[PW-1:0];
        end
      end
    end
    for (gi = 0; gi < 2; gi++) begin : g_prog
      for (gj = 0; gj < PD; gj++) begin : g_word
        always_ff @(posedge hclk or negedge hresetn) begin
          if (!hresetn) begin
            prog_q[gi][gj] <= 16'h0000;
          end else if (wr_pend_q && wr_addr_q == 8'(`MCB_OFS_PROG_BASE + 4 * (gi * PD + gj))) begin
            prog_q[gi][gj] <= hwdata[15:0];
          end
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // command decode
  // --------------------------------------------------------------------------
  // a change of a toggle bit is one command, whichever way it flips
  assign chg        = cmd_q ^ cmd_prev_q;
  assign home_go[0] = chg[`MCB_CMD_HOME_A];
  assign home_go[1] = chg[`MCB_CMD_HOME_B];
  assign run_req[0] = chg[`MCB_CMD_RUN_A];
  assign run_req[1] = chg[`MCB_CMD_RUN_B];

  // programs need local logic on and no error pending
  assign run_go     = run_req & {2{logic_en_q && !err_pending}} & drv_en;
  assign refused    = |(run_req & ~run_go);
  assign drv_en     = {drive_en_b, drive_en_a};

  // local logic enable follows its level bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      logic_en_q <= 1'b0;
    end else begin
      logic_en_q <= cmd_q[`MCB_CMD_LOGIC_EN];
    end
  end

  // drive enables; a fault drops both drives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_en_a <= 1'b0;
      drive_en_b <= 1'b0;
    end else if (fault) begin
      drive_en_a <= 1'b0;
      drive_en_b <= 1'b0;
    end else begin
      if (chg[`MCB_CMD_DRV_A]) begin
        drive_en_a <= 1'b1;
      end
      if (chg[`MCB_CMD_DRV_B]) begin
        drive_en_b <= 1'b1;
      end
    end
  end

  // error pending; a new fault wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_pending <= 1'b0;
    end else if (fault) begin
      err_pending <= 1'b1;
    end else if (chg[`MCB_CMD_CLR_ERR] && err_pending) begin
      err_pending <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // axes: A is master of B's cam and B of A's
  // --------------------------------------------------------------------------
  generate
    for (gi = 0; gi < 2; gi++) begin : g_axis
      mcb_axis #(
        .PW        (PW),
        .AW        (AW),
        .HOME_CYC  (HOME_CYC),
        .DWELL_CYC (`MCB_DWELL_CYC)
      ) u_axis (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .drive_en   (drv_en[gi]),
        .home_go    (home_go[gi]),
        .run_go     (run_go[gi]),
        .abort      (err_pending),
        .stmt       (prog_q[gi][pc[gi]]),
        .cam_val    (cam_q[pos[1-gi][CAM_SHIFT +: CAM_AW]]),
        .master_pos (pos[1-gi]),
        .pc         (pc[gi]),
        .pos        (pos[gi]),
        .pos_valid  (pvalid[gi]),
        .busy       (busy[gi]),
        .dwelling   (dwell[gi]),
        .home_done  (home_done[gi]),
        .prog_done  (prog_done[gi])
      );
    end
  endgenerate

  // registered copies of position valid for the pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos_valid_a <= 1'b0;
      pos_valid_b <= 1'b0;
    end else begin
      pos_valid_a <= pvalid[0];
      pos_valid_b <= pvalid[1];
    end
  end

  // --------------------------------------------------------------------------
  // interrupts
  // --------------------------------------------------------------------------
  logic [`MCB_IRQ_W-1:0] ev;
  logic                  rd_irq;

  assign ev     = {refused, fault && !err_pending, prog_done[1], prog_done[0], home_done[1], home_done[0]};
  assign rd_irq = take && !hwrite && is_reg(a8, `MCB_OFS_IRQ_STAT);

  // sticky status, read clears, a new event in the same cycle survives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (rd_irq ? '0 : irq_stat_q) | ev;
    end
  end

  // level interrupt while any unmasked bit stands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((rd_irq ? '0 : irq_stat_q) | ev) & irq_mask_q);
    end
  end

  // --------------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------------
  logic [63:0] stat;
  logic [31:0] rd_d;

  // status image: error bit plus the two position valid bits
  always_comb begin
    stat                     = 64'h0;
    stat[`MCB_STAT_ERR]      = err_pending;
    stat[`MCB_STAT_PVALID_A] = pvalid[0];
    stat[`MCB_STAT_PVALID_B] = pvalid[1];
  end

  // read mux, unmapped words read zero
  always_comb begin
    rd_d = 32'h0;
    if (is_reg(a8, `MCB_OFS_CMD_LO)) begin
      rd_d = cmd_q[31:0];
    end else if (is_reg(a8, `MCB_OFS_CMD_HI)) begin
      rd_d = cmd_q[63:32];
    end else if (is_reg(a8, `MCB_OFS_STAT_LO)) begin
      rd_d = stat[31:0];
    end else if (is_reg(a8, `MCB_OFS_STAT_HI)) begin
      rd_d = stat[63:32];
    end else if (is_reg(a8, `MCB_OFS_IRQ_STAT)) begin
      rd_d = 32'(irq_stat_q);
    end else if (is_reg(a8, `MCB_OFS_IRQ_MASK)) begin
      rd_d = 32'(irq_mask_q);
    end else if (is_reg(a8, `MCB_OFS_STATE)) begin
      // flags in the low byte, then pc a and pc b
      rd_d = {8'h00, 8'(pc[1]), 8'(pc[0]),
              dwell, busy, drv_en,
              logic_en_q, err_pending};
    end else if (a8[7:6] == 2'b01 && a8[5:2] < 4'(CD)) begin
      rd_d = 32'(cam_q[a8[2 +: CAM_AW]]);
    end else if (a8[7] && a8[6:2] < 5'(2 * PD)) begin
      rd_d = 32'(prog_q[a8[2 + AW]][a8[2 +: AW]]);
    end
  end

  // read data registered at the address phase edge, stands through the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (take && !hwrite) begin
      hrdata <= rd_d;
    end
  end

  // position words are not in the state register, which shows pc and the flags only; pos is for the cam path
endmodule : mcb_top

// ===== verilog/mcb_params.svh
// Purpose: offsets, field positions, reset values and timing counts of the motion command block
// Assumes: 50 MHz hclk, AHB-Lite word registers
// Notes:   included by bare name; definitions only
`ifndef MCB_PARAMS_SVH
`define MCB_PARAMS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define MCB_OFS_CMD_LO     8'h00
`define MCB_OFS_CMD_HI     8'h04
`define MCB_OFS_STAT_LO    8'h08
`define MCB_OFS_STAT_HI    8'h0c
`define MCB_OFS_IRQ_STAT   8'h10
`define MCB_OFS_IRQ_MASK   8'h14
`define MCB_OFS_STATE      8'h18
`define MCB_OFS_CAM_BASE   8'h40
`define MCB_OFS_PROG_BASE  8'h80

// ----------------------------------------------------------------------------
// command bit offsets (host output image, 64 bits)
// ----------------------------------------------------------------------------
`define MCB_CMD_CLR_ERR    0
`define MCB_CMD_LOGIC_EN   1
`define MCB_CMD_RUN_A      2
`define MCB_CMD_RUN_B      3
`define MCB_CMD_DRV_A      18
`define MCB_CMD_HOME_A     19
`define MCB_CMD_DRV_B      34
`define MCB_CMD_HOME_B     35

// ----------------------------------------------------------------------------
// status bit offsets (module input image, 64 bits)
// ----------------------------------------------------------------------------
`define MCB_STAT_ERR       0
`define MCB_STAT_PVALID_A  17
`define MCB_STAT_PVALID_B  33

// ----------------------------------------------------------------------------
// interrupt bits and reset values
// ----------------------------------------------------------------------------
`define MCB_IRQ_HOME_A     0
`define MCB_IRQ_HOME_B     1
`define MCB_IRQ_DONE_A     2
`define MCB_IRQ_DONE_B     3
`define MCB_IRQ_ERR        4
`define MCB_IRQ_REFUSED    5
`define MCB_IRQ_W          6
`define MCB_IRQ_MASK_RST   6'h00

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define MCB_CLK_MHZ        50
`define MCB_HOME_TIME_US   10
`define MCB_HOME_CYC       (`MCB_HOME_TIME_US * `MCB_CLK_MHZ)
`define MCB_DWELL_UNIT_US  1
`define MCB_DWELL_CYC      (`MCB_DWELL_UNIT_US * `MCB_CLK_MHZ)

`endif

// ===== verilog/mcb_pkg.sv
// Purpose: types of the motion command block
// Assumes: nothing beyond SystemVerilog packages
// Notes:   numbers live in mcb_params.svh
package mcb_pkg;

  // axis sequencer states, gray along idle-fetch-move-dwell-cam
  typedef enum logic [2:0] {
    MCB_IDLE  = 3'h0,
    MCB_FETCH = 3'h1,
    MCB_MOVE  = 3'h3,
    MCB_DWELL = 3'h2,
    MCB_CAM   = 3'h6,
    MCB_HOME  = 3'h4
  } mcb_axis_st_t;

  // program statement opcodes, bits 15:14 of a statement
  typedef enum logic [1:0] {
    MCB_OP_END   = 2'h0,
    MCB_OP_MOVE  = 2'h1,
    MCB_OP_DWELL = 2'h2,
    MCB_OP_CAM   = 2'h3
  } mcb_op_t;

endpackage : mcb_pkg

// ===== verilog/mcb_axis.sv
// Purpose: one axis: find-home cycle, statement sequencer with move, dwell and cam follow
// Assumes: go pulses one cycle wide, statement valid for the current pc
// Notes:   position is unsigned; move steps one count per clock
`timescale 1ns/1ps
`include "mcb_params.svh"
module mcb_axis import mcb_pkg::*; #(
  parameter int PW       = 16,
  parameter int AW       = 3,
  parameter int HOME_CYC = `MCB_HOME_CYC,
  parameter int DWELL_CYC = `MCB_DWELL_CYC
) (
  // clock and reset
  input  wire logic          hclk,
  input  wire logic          hresetn,
  // commands
  input  wire logic          drive_en,
  input  wire logic          home_go,
  input  wire logic          run_go,
  input  wire logic          abort,
  // program and cam
  input  wire logic [15:0]   stmt,
  input  wire logic [PW-1:0] cam_val,
  input  wire logic [PW-1:0] master_pos,
  // state
  output logic      [AW-1:0] pc,
  output logic      [PW-1:0] pos,
  output logic               pos_valid,
  output logic               busy,
  output logic               dwelling,
  output logic               home_done,
  output logic               prog_done
);

  mcb_axis_st_t   st_q;
  logic [23:0]    cnt_q;
  logic [PW-1:0]  tgt_q;
  logic           adv;
  logic [PW-1:0]  imm;
  mcb_op_t        op;

  // statement decode and finish of the current statement
  assign op  = mcb_op_t'(stmt[15:14]);
  assign imm = PW'(stmt[13:0]);
  assign adv = (st_q == MCB_MOVE && pos == tgt_q) || (st_q == MCB_DWELL && cnt_q == 24'h0) ||
               (st_q == MCB_CAM && master_pos >= tgt_q);

  // sequencer; an abort drops back to idle but keeps the position
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q      <= MCB_IDLE;
      cnt_q     <= 24'h0;
      tgt_q     <= '0;
      pc        <= '0;
      home_done <= 1'b0;
      prog_done <= 1'b0;
    end else begin
      home_done <= 1'b0;
      prog_done <= 1'b0;
      if (abort) begin
        st_q <= MCB_IDLE;
      end else begin
        case (st_q)
          MCB_IDLE: begin
            if (home_go && drive_en) begin
              st_q  <= MCB_HOME;
              cnt_q <= 24'(HOME_CYC - 1);
            end else if (run_go && drive_en) begin
              st_q <= MCB_FETCH;
              pc   <= '0;
            end
          end
          MCB_HOME: begin
            if (cnt_q == 24'h0) begin
              st_q      <= MCB_IDLE;
              home_done <= 1'b1;
            end else begin
              cnt_q <= cnt_q - 24'h1;
            end
          end
          MCB_FETCH: begin
            tgt_q <= imm;
            case (op)
              MCB_OP_END: begin
                st_q      <= MCB_IDLE;
                prog_done <= 1'b1;
              end
              MCB_OP_MOVE:  st_q <= MCB_MOVE;
              MCB_OP_DWELL: begin
                st_q  <= MCB_DWELL;
                cnt_q <= 24'(stmt[13:0] * DWELL_CYC);  // one extra cycle per dwell, on purpose
              end
              MCB_OP_CAM:   st_q <= MCB_CAM;
              default:      st_q <= MCB_IDLE;
            endcase
          end
          MCB_MOVE, MCB_DWELL, MCB_CAM: begin
            if (st_q == MCB_DWELL && cnt_q != 24'h0) begin
              cnt_q <= cnt_q - 24'h1;
            end
            if (adv) begin
              // running off the end of the program ends it
              if (pc == {AW{1'b1}}) begin
                st_q      <= MCB_IDLE;
                prog_done <= 1'b1;
              end else begin
                pc   <= pc + AW'(1);
                st_q <= MCB_FETCH;
              end
            end
          end
          default: st_q <= MCB_IDLE;
        endcase
      end
    end
  end

  // commanded position
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos <= '0;
    end else if (st_q == MCB_HOME && cnt_q == 24'h0 && !abort) begin
      pos <= '0;
    end else if (st_q == MCB_MOVE && pos != tgt_q) begin
      pos <= (pos < tgt_q) ? pos + PW'(1) : pos - PW'(1);
    end else if (st_q == MCB_CAM) begin
      pos <= cam_val;
    end
  end

  // position valid: cleared when homing starts, set when it ends
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos_valid <= 1'b0;
    end else if (st_q == MCB_IDLE && home_go && drive_en && !abort) begin
      pos_valid <= 1'b0;
    end else if (st_q == MCB_HOME && cnt_q == 24'h0 && !abort) begin
      pos_valid <= 1'b1;
    end
  end

  // flags for the state word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy     <= 1'b0;
      dwelling <= 1'b0;
    end else begin
      busy     <= (st_q != MCB_IDLE);
      dwelling <= (st_q == MCB_DWELL);
    end
  end

endmodule : mcb_axis

// ===== test/mcb_checker.sv
// Purpose: port assertions for the motion command block
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to every mcb_top at the foot of this file
`timescale 1ns/1ps
module mcb_checker (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // drive side
  input wire logic        fault,
  input wire logic        drive_en_a,
  input wire logic        drive_en_b,
  input wire logic        pos_valid_a,
  input wire logic        pos_valid_b,
  input wire logic        err_pending
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // error latched and both drives dropped
  sequence s_fault_off;
    err_pending && !drive_en_a && !drive_en_b;
  endsequence

  // a read whose data is loaded at this edge
  sequence s_rd_taken;
    hsel && hready && htrans[1] && !hwrite;
  endsequence

  a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
  a_ready_high: assert property ($past(hresetn) |-> hreadyout) else $error("wait state seen");
  a_rdata_hold: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("hrdata moved without read");
  a_fault_drops: assert property (fault |=> s_fault_off) else $error("fault not taken");
  a_err_keep: assert property ($fell(err_pending) |-> !$past(fault)) else $error("clear beat fault");
  a_drive_a_hold: assert property (drive_en_a && !fault |=> drive_en_a) else $error("drive a lost");
  a_drive_b_hold: assert property (drive_en_b && !fault |=> drive_en_b) else $error("drive b lost");
  a_valid_a_drive: assert property ($rose(pos_valid_a) |-> $past(drive_en_a, 2))
    else $error("axis a homed undriven");
  a_valid_b_drive: assert property ($rose(pos_valid_b) |-> $past(drive_en_b, 2))
    else $error("axis b homed undriven");
  c_read: cover property (s_rd_taken);
endmodule : mcb_checker

bind mcb_top mcb_checker i_mcb_checker (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata,
  .hreadyout, .hresp, .fault, .drive_en_a, .drive_en_b, .pos_valid_a, .pos_valid_b, .err_pending);

// ===== test/mcb_host_model.sv
// Purpose: host side, single-word bus master holding the command image
// Assumes: zero or more wait states, answer always okay
// Notes:   hwdata shows inverted junk outside its data phase
`timescale 1ns/1ps
module mcb_host_model (
  // clock and answer
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // request
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  logic [63:0] img_q;

  // idle bus at time zero
  initial begin
    img_q = 64'h0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // address phase held until hready, then data phase held until hready
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    hwdata <= ~d;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    xfer(a, 1'b0, 32'h0, r);
  endtask : rd

  // flip one command bit and send the half holding it
  task automatic toggle(input int b);
    img_q[b] = ~img_q[b];
    wr(b < 32 ? 8'h00 : 8'h04, b < 32 ? img_q[31:0] : img_q[63:32]);
  endtask : toggle

  // local logic enable is a level, not a toggle
  task automatic set_logic(input logic v);
    img_q[1] = v;
    wr(8'h00, img_q[31:0]);
  endtask : set_logic
endmodule : mcb_host_model

// ===== test/motion_command_bit_decoder_tb_top.sv
// Purpose: self-checking bench for the motion command block
// Assumes: home count shortened to 4 cycles
// Notes:   expectations worked out from bit offsets, never read back
`timescale 1ns/1ps
`include "mcb_params.svh"
module motion_command_bit_decoder_tb_top;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        fault = 1'b0;
  logic        hsel, hwrite, hready, hreadyout, hresp, irq, err_pending;
  logic        drive_en_a, drive_en_b, pos_valid_a, pos_valid_b;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  int          num_errors = 0;
  int          num_checks = 0;

  always #10 hclk = ~hclk;
  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  mcb_top #(.HOME_CYC(4)) i_mcb_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .fault, .drive_en_a, .drive_en_b,
    .pos_valid_a, .pos_valid_b, .err_pending, .irq);
  mcb_host_model i_mcb_host_model (.hclk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata);

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  // settle a little past the edge so flops have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : cyc

  // bounded wait on the interrupt pin
  task automatic wait_irq;
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 500) begin
      cyc(1);
      k++;
    end
    chk("irq rise", 32'(irq), 32'h1);
  endtask : wait_irq

  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // mask resets clear, unmapped word reads zero
  task automatic t_regs;
    i_mcb_host_model.rd(`MCB_OFS_IRQ_MASK, r);
    chk("irq mask", r, 32'h0);
    i_mcb_host_model.wr(8'h3c, 32'hffffffff);
    i_mcb_host_model.rd(8'h3c, r);
    chk("unmapped", r, 32'h0);
  endtask : t_regs

  // second toggle must not turn the drive off
  task automatic t_drive;
    i_mcb_host_model.toggle(`MCB_CMD_DRV_A);
    i_mcb_host_model.toggle(`MCB_CMD_DRV_B);
    cyc(3);
    chk("drive a", 32'(drive_en_a), 32'h1);
    chk("drive b", 32'(drive_en_b), 32'h1);
    i_mcb_host_model.toggle(`MCB_CMD_DRV_A);
    cyc(3);
    chk("drive a kept", 32'(drive_en_a), 32'h1);
  endtask : t_drive

  // homing with the interrupt masked, then unmasked and read-cleared
  task automatic t_home;
    i_mcb_host_model.toggle(`MCB_CMD_HOME_A);
    i_mcb_host_model.toggle(`MCB_CMD_HOME_B);
    cyc(12);
    chk("irq masked", 32'(irq), 32'h0);
    i_mcb_host_model.rd(`MCB_OFS_STAT_LO, r);
    chk("valid a", r & 32'h20000, 32'h20000);
    i_mcb_host_model.rd(`MCB_OFS_STAT_HI, r);
    chk("valid b", r & 32'h2, 32'h2);
    chk("valid pins", 32'({pos_valid_b, pos_valid_a}), 32'h3);
    i_mcb_host_model.wr(`MCB_OFS_IRQ_MASK, 32'h3);
    cyc(2);
    chk("irq on", 32'(irq), 32'h1);
    i_mcb_host_model.rd(`MCB_OFS_IRQ_STAT, r);
    chk("home events", r, 32'h3);
    cyc(2);
    chk("irq cleared", 32'(irq), 32'h0);
  endtask : t_home

  // dwell then end on a, a short move on b
  task automatic t_run;
    i_mcb_host_model.wr(`MCB_OFS_PROG_BASE, 32'h8002);
    i_mcb_host_model.wr(8'h84, 32'h0);
    i_mcb_host_model.wr(8'ha0, 32'h4005);
    i_mcb_host_model.wr(8'ha4, 32'h0);
    i_mcb_host_model.wr(`MCB_OFS_IRQ_MASK, 32'hc);
    i_mcb_host_model.set_logic(1'b1);
    i_mcb_host_model.toggle(`MCB_CMD_RUN_A);
    cyc(8);
    i_mcb_host_model.rd(`MCB_OFS_STATE, r);
    chk("dwell a", r & 32'h50, 32'h50);
    wait_irq();
    i_mcb_host_model.rd(`MCB_OFS_IRQ_STAT, r);
    chk("done a", r, 32'h4);
    i_mcb_host_model.toggle(`MCB_CMD_RUN_B);
    wait_irq();
    i_mcb_host_model.rd(`MCB_OFS_IRQ_STAT, r);
    chk("done b", r, 32'h8);
  endtask : t_run

  // runs refused under error and with the drive off
  task automatic t_fault;
    @(posedge hclk);
    fault <= 1'b1;
    @(posedge hclk);
    fault <= 1'b0;
    cyc(2);
    chk("fault", 32'({err_pending, drive_en_b, drive_en_a}), 32'h4);
    i_mcb_host_model.toggle(`MCB_CMD_DRV_A);
    i_mcb_host_model.toggle(`MCB_CMD_RUN_A);
    cyc(3);
    i_mcb_host_model.rd(`MCB_OFS_IRQ_STAT, r);
    chk("run in error", r, 32'h30);
    i_mcb_host_model.toggle(`MCB_CMD_CLR_ERR);
    cyc(3);
    chk("err clear", 32'(err_pending), 32'h0);
    i_mcb_host_model.toggle(`MCB_CMD_RUN_B);
    cyc(3);
    i_mcb_host_model.rd(`MCB_OFS_STATE, r);
    chk("b idle", r & 32'hffff20, 32'h10100);
    i_mcb_host_model.rd(`MCB_OFS_IRQ_STAT, r);
    chk("run refused", r, 32'h20);
  endtask : t_fault

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    cyc(2);
    t_regs();
    t_drive();
    t_home();
    t_run();
    t_fault();
    stop_test();
  end

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #400000;
    num_errors++;
    stop_test();
  end
endmodule : motion_command_bit_decoder_tb_top
